// [src/mcr_map.svh]
// What this block does
// - the decimation ratio is 8 * (4 + bandwidth mantissa) * 2^bandwidth exponent.
// - the symbol rate is an unsigned float, 8-bit mantissa plus hidden one, 4-bit exponent.
// - data rate is (256 + rate mantissa) * 2^rate exponent / 2^28 times the reference clock.
// - bit 7 of the third register at one bypasses the dc blocking filter, at zero keeps it.
// - modulation code 000 is 2-fsk, 001 gaussian fsk, 011 on-off keying, others undefined.
// - rate exponent is bits 3:0 of the first register, reset 1100; bw exp resets 10, bw mant 00.
// - the rate mantissa fills the second register and resets to 0x22.
`ifndef MCR_MAP_SVH
`define MCR_MAP_SVH

// ----------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------
`define MCR_IDX_BW_EXP      16'hDF0C
`define MCR_IDX_MANT        16'hDF0D
`define MCR_IDX_FILT_MOD    16'hDF0E

// ----------------------------------------
// reset values
// ----------------------------------------
`define MCR_RST_BW_EXP      8'h8C
`define MCR_RST_MANT        8'h22
`define MCR_RST_FILT_MOD    8'h02

// ----------------------------------------
// field positions
// ----------------------------------------
`define MCR_BW_E_MSB        7
`define MCR_BW_E_LSB        6
`define MCR_BW_M_MSB        5
`define MCR_BW_M_LSB        4
`define MCR_RATE_E_MSB      3
`define MCR_RATE_E_LSB      0
`define MCR_DC_BYPASS_BIT   7
`define MCR_MOD_MSB         6
`define MCR_MOD_LSB         4

// ----------------------------------------
// arithmetic constants
// ----------------------------------------
`define MCR_BW_OFFSET       4'h4
`define MCR_BW_SHIFT        3
`define MCR_RATE_HIDDEN     9'h100
`define MCR_NCO_W           28

`endif

// [src/mcr_pkg.sv]
package mcr_pkg;
    typedef enum logic [2:0] {
        MCR_MOD_FSK2 = 3'b000,
        MCR_MOD_GFSK = 3'b001,
        MCR_MOD_OOK  = 3'b011
    } mcr_mod_e;

    typedef logic [7:0]  mcr_byte_t;
    typedef logic [23:0] mcr_rate_word_t;
endpackage

// [src/mcr_rate_nco.sv]
`timescale 1ns/1ps
`include "mcr_map.svh"
module mcr_rate_nco #(
    parameter int ACC_W = `MCR_NCO_W
) (
    // clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // rate word
    input  wire mcr_pkg::mcr_rate_word_t rate_word,
    // symbol strobe
    output logic                        sym_tick
);
    generate
        if (ACC_W <= $bits(mcr_pkg::mcr_rate_word_t)) begin : g_chk
            $error("mcr_rate_nco: accumulator narrower than rate word");
        end
    endgenerate

    logic [ACC_W-1:0] acc_reg;
    logic [ACC_W-1:0] acc_next;
    logic             tick_reg;
    logic             tick_next;

    // carry out of the accumulator marks one symbol: rate = word / 2^ACC_W * f_clk
    always_comb begin
        {tick_next, acc_next} = {1'b0, acc_reg} + (ACC_W+1)'(rate_word);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            acc_reg  <= acc_next;
            tick_reg <= tick_next;
        end
    end

    assign sym_tick = tick_reg;
endmodule // mcr_rate_nco

// [src/mcr_regs.sv]
`timescale 1ns/1ps
`include "mcr_map.svh"
module mcr_regs #(
    parameter int ADDR_W = 18
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // receiver fields
    output logic [1:0]             bandwidth_exponent,
    output logic [1:0]             bandwidth_mantissa,
    output logic [9:0]             decim_ratio,
    output logic                   dc_block_bypass,
    output logic                   dc_block_enable,
    // rate fields
    output logic [3:0]             rate_exponent,
    output logic [7:0]             rate_mantissa_field,
    output mcr_pkg::mcr_rate_word_t rate_word,
    output logic                   sym_tick,
    // modulation
    output logic [2:0]             modulation_select,
    output logic                   mod_fsk2,
    output logic                   mod_gfsk,
    output logic                   mod_ook,
    output logic                   mod_undefined,
    // low bits of third register, kept as storage
    output logic [3:0]             filt_low_bits
);
    generate
        if (ADDR_W < 18) begin : g_chk
            $error("mcr_regs: address too narrow for register map");
        end
    endgenerate

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_BW_EXP   = ADDR_W'({`MCR_IDX_BW_EXP, 2'b00});
    localparam logic [ADDR_W-1:0] ADDR_MANT     = ADDR_W'({`MCR_IDX_MANT, 2'b00});
    localparam logic [ADDR_W-1:0] ADDR_FILT_MOD = ADDR_W'({`MCR_IDX_FILT_MOD, 2'b00});

    logic hit_bw;
    logic hit_mant;
    logic hit_filt;
    logic hit_any;
    logic setup;
    logic wr_en;

    assign hit_bw   = (paddr == ADDR_BW_EXP);
    assign hit_mant = (paddr == ADDR_MANT);
    assign hit_filt = (paddr == ADDR_FILT_MOD);
    assign hit_any  = hit_bw | hit_mant | hit_filt;
    assign setup    = psel & ~penable;
    // no wait states; data lives in byte lane 0 only
    assign wr_en    = psel & penable & pwrite & pstrb[0];
    assign pready   = 1'b1;

    // ----------------------------------------
    // register storage
    // ----------------------------------------
    mcr_pkg::mcr_byte_t bw_exp_reg;
    mcr_pkg::mcr_byte_t bw_exp_next;
    mcr_pkg::mcr_byte_t mant_reg;
    mcr_pkg::mcr_byte_t mant_next;
    mcr_pkg::mcr_byte_t filt_reg;
    mcr_pkg::mcr_byte_t filt_next;
    logic [31:0]        rdata_reg;
    logic [31:0]        rdata_next;
    logic               err_reg;
    logic               err_next;

    always_comb begin
        bw_exp_next = bw_exp_reg;
        mant_next   = mant_reg;
        filt_next   = filt_reg;
        // write lands at the access edge, fields follow next cycle
        if (wr_en && hit_bw) begin
            bw_exp_next = pwdata[7:0];
        end
        if (wr_en && hit_mant) begin
            mant_next = pwdata[7:0];
        end
        if (wr_en && hit_filt) begin
            filt_next = pwdata[7:0];
        end
        rdata_next = rdata_reg;
        err_next   = err_reg;
        // read data sampled in setup so prdata comes from a flop
        if (setup) begin
            err_next = ~hit_any;
            unique case (1'b1)
                hit_bw:   rdata_next = {24'h000000, bw_exp_reg};
                hit_mant: rdata_next = {24'h000000, mant_reg};
                hit_filt: rdata_next = {24'h000000, filt_reg};
                default:  rdata_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bw_exp_reg <= `MCR_RST_BW_EXP;
            mant_reg   <= `MCR_RST_MANT;
            filt_reg   <= `MCR_RST_FILT_MOD;
            rdata_reg  <= 32'h00000000;
            err_reg    <= 1'b0;
        end else begin
            bw_exp_reg <= bw_exp_next;
            mant_reg   <= mant_next;
            filt_reg   <= filt_next;
            rdata_reg  <= rdata_next;
            err_reg    <= err_next;
        end
    end

    assign prdata  = rdata_reg;
    assign pslverr = err_reg & psel & penable;

    // ----------------------------------------
    // field decode for the modem
    // ----------------------------------------
    assign bandwidth_exponent  = bw_exp_reg[`MCR_BW_E_MSB:`MCR_BW_E_LSB];
    assign bandwidth_mantissa  = bw_exp_reg[`MCR_BW_M_MSB:`MCR_BW_M_LSB];
    assign rate_exponent       = bw_exp_reg[`MCR_RATE_E_MSB:`MCR_RATE_E_LSB];
    assign rate_mantissa_field = mant_reg;
    assign dc_block_bypass     = filt_reg[`MCR_DC_BYPASS_BIT];
    assign dc_block_enable     = ~filt_reg[`MCR_DC_BYPASS_BIT];
    assign modulation_select   = filt_reg[`MCR_MOD_MSB:`MCR_MOD_LSB];
    assign filt_low_bits       = filt_reg[3:0];

    // 8*(4+m) << e; widest case 7*8*8 = 448 fits ten bits
    assign decim_ratio = 10'({`MCR_BW_OFFSET + {2'b00, bandwidth_mantissa}, 3'b000}
                             << bandwidth_exponent);

    // hidden ninth bit; widest case 511 << 15 fits 24 bits
    assign rate_word = 24'(({`MCR_RATE_HIDDEN | {1'b0, mant_reg}}) << rate_exponent);

    always_comb begin
        mod_fsk2      = 1'b0;
        mod_gfsk      = 1'b0;
        mod_ook       = 1'b0;
        mod_undefined = 1'b0;
        unique case (modulation_select)
            mcr_pkg::MCR_MOD_FSK2: mod_fsk2 = 1'b1;
            mcr_pkg::MCR_MOD_GFSK: mod_gfsk = 1'b1;
            mcr_pkg::MCR_MOD_OOK:  mod_ook  = 1'b1;
            // codes with no defined format are flagged, never guessed
            default:               mod_undefined = 1'b1;
        endcase
    end

    // ----------------------------------------
    // symbol rate generator on the reference clock
    // ----------------------------------------
    mcr_rate_nco #(
        .ACC_W (`MCR_NCO_W)
    ) u_nco (
        .pclk      (pclk),
        .presetn   (presetn),
        .rate_word (rate_word),
        .sym_tick  (sym_tick)
    );

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    sequence s_wr_mant;
        psel && penable && pwrite && pstrb[0] && hit_mant;
    endsequence

    sequence s_rd_bw;
        psel && !penable && !pwrite && hit_bw ##1 psel && penable && !pwrite && !wr_en;
    endsequence

    property p_decim;
        @(posedge pclk) disable iff (!presetn)
        32'(decim_ratio) == 8 * (4 + 32'(bandwidth_mantissa)) * (1 << bandwidth_exponent);
    endproperty
    a_decim: assert property (p_decim) else $error("decimation ratio wrong");

    property p_rate_word;
        @(posedge pclk) disable iff (!presetn)
        32'(rate_word) == (256 + 32'(rate_mantissa_field)) * (1 << rate_exponent);
    endproperty
    a_rate_word: assert property (p_rate_word) else $error("rate word wrong");

    property p_tick_gap;
        @(posedge pclk) disable iff (!presetn)
        sym_tick |=> !sym_tick;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("symbol ticks too close");

    property p_bypass;
        @(posedge pclk) disable iff (!presetn)
        wr_en && hit_filt |=> dc_block_bypass == $past(pwdata[7])
                              && dc_block_enable != dc_block_bypass;
    endproperty
    a_bypass: assert property (p_bypass) else $error("dc filter bypass wrong");

    property p_mod;
        @(posedge pclk) disable iff (!presetn)
        $onehot({mod_fsk2, mod_gfsk, mod_ook, mod_undefined})
        && (mod_ook == (modulation_select == 3'b011))
        && (mod_gfsk == (modulation_select == 3'b001));
    endproperty
    a_mod: assert property (p_mod) else $error("modulation decode wrong");

    property p_rst_exp;
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> rate_exponent == 4'hC && bandwidth_exponent == 2'h2
                           && bandwidth_mantissa == 2'h0;
    endproperty
    a_rst_exp: assert property (p_rst_exp) else $error("exponent reset wrong");

    property p_rst_mant;
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> rate_mantissa_field == 8'h22;
    endproperty
    a_rst_mant: assert property (p_rst_mant) else $error("mantissa reset wrong");

    property p_wr_mant;
        @(posedge pclk) disable iff (!presetn)
        s_wr_mant |=> rate_mantissa_field == $past(pwdata[7:0]);
    endproperty
    a_wr_mant: assert property (p_wr_mant) else $error("mantissa write lost");

    property p_rd_bw;
        @(posedge pclk) disable iff (!presetn)
        s_rd_bw |-> prdata == {24'h000000, bw_exp_reg} && !pslverr;
    endproperty
    a_rd_bw: assert property (p_rd_bw) else $error("read data wrong");
endmodule // mcr_regs

// [tb/mcr_tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam logic [17:0] A_BWE = 18'h37C30;
    localparam logic [17:0] A_MNT = 18'h37C34;
    localparam logic [17:0] A_FLT = 18'h37C38;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [17:0] paddr = 18'h00000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0]  pstrb = 4'hF;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  bw_e;
    logic [1:0]  bw_m;
    logic [9:0]  decim;
    logic        byp;
    logic        dc_en;
    logic [3:0]  rate_e;
    logic [7:0]  rate_m;
    logic [23:0] rword;
    logic        tick;
    logic [2:0]  mod_sel;
    logic        m_fsk2;
    logic        m_gfsk;
    logic        m_ook;
    logic        m_undef;
    logic [3:0]  low_bits;
    int          err_count = 0;
    int          n_compared = 0;
    logic [31:0] rd;
    logic        er;
    logic [7:0]  v;
    int          cnt;
    int          nw;
    logic [7:0]  bwv [3] = '{8'hFF, 8'h00, 8'h5B};
    logic [7:0]  mv [3] = '{8'h00, 8'hFF, 8'hA5};

    always #5 pclk = ~pclk;

    mcr_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bandwidth_exponent(bw_e),
        .bandwidth_mantissa(bw_m), .decim_ratio(decim), .dc_block_bypass(byp),
        .dc_block_enable(dc_en), .rate_exponent(rate_e), .rate_mantissa_field(rate_m),
        .rate_word(rword), .sym_tick(tick), .modulation_select(mod_sel),
        .mod_fsk2(m_fsk2), .mod_gfsk(m_gfsk), .mod_ook(m_ook), .mod_undefined(m_undef),
        .filt_low_bits(low_bits));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // no wait-state count assumed: loop on pready, watchdog ends a hang
    task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        nw = n;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic [17:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h000000, d}, 4'hF, rd, er);
    endtask

    task automatic rchk(input string nm, input logic [17:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h00000000, 4'hF, rd, er);
        chk(nm, {24'h000000, e}, rd);
        chk("pslverr", 32'h0, {31'h0, er});
        chk("pready_wait", 32'h1, nw);
    endtask

    task automatic fchk(input logic [7:0] b, input logic [7:0] m);
        chk("rate_exponent", {28'h0, b[3:0]}, {28'h0, rate_e});
        chk("bw_exp", {30'h0, b[7:6]}, {30'h0, bw_e});
        chk("bw_mant", {30'h0, b[5:4]}, {30'h0, bw_m});
        chk("decim", ((32'h4 + b[5:4]) * 32'h8) << b[7:6], {22'h0, decim});
        chk("rate_mant", {24'h0, m}, {24'h0, rate_m});
        chk("rate_word", (32'h100 + m) << b[3:0], {8'h0, rword});
        rchk("bw_reg", A_BWE, b);
        rchk("mant_reg", A_MNT, m);
    endtask

    task automatic give_verdict;
        if (err_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ----------------------------------------
    // watchdog, well beyond the expected run
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        give_verdict();
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        fchk(8'h8C, 8'h22);
        rchk("filt_reg", A_FLT, 8'h02);
        for (int i = 0; i < 3; i++) begin
            wr(A_BWE, bwv[i]);
            wr(A_MNT, mv[i]);
            fchk(bwv[i], mv[i]);
        end
        for (int c = 0; c < 8; c++) begin
            v = {c[0], c[2:0], c[3:0] ^ 4'hA};
            // rate is near 321 kbps here, so bypass is allowed; if setting lives elsewhere
            wr(A_FLT, v);
            chk("mod_sel", c, {29'h0, mod_sel});
            chk("fsk2", {31'h0, c == 0}, {31'h0, m_fsk2});
            chk("gfsk", {31'h0, c == 1}, {31'h0, m_gfsk});
            chk("ook", {31'h0, c == 3}, {31'h0, m_ook});
            chk("undef", {31'h0, c == 2 || c > 3}, {31'h0, m_undef});
            chk("bypass", {31'h0, v[7]}, {31'h0, byp});
            chk("dc_en", {31'h0, !v[7]}, {31'h0, dc_en});
            chk("low", {28'h0, v[3:0]}, {28'h0, low_bits});
            rchk("filt_reg", A_FLT, v);
        end
        // refused accesses leave stored values alone; a mapped write keeps byte lane 0 only
        apb(1'b1, 18'h37C3C, 32'h000000FF, 4'hF, rd, er);
        chk("wr_err", 32'h1, {31'h0, er});
        apb(1'b0, 18'h37C3C, 32'h00000000, 4'hF, rd, er);
        chk("rd_err", 32'h1, {31'h0, er});
        chk("rd_unmapped", 32'h0, rd);
        apb(1'b1, A_BWE, 32'h00000000, 4'h0, rd, er);
        apb(1'b1, A_MNT, 32'hFFFFFF11, 4'hF, rd, er);
        fchk(8'h5B, 8'h11);
        // fastest rate: 511 << 15 per clock over 2^28
        wr(A_BWE, 8'h0F);
        wr(A_MNT, 8'hFF);
        cnt = 0;
        repeat (1600) begin
            @(posedge pclk);
            cnt += (tick === 1'b1);
        end
        chk("tick_lo", 32'h1, {31'h0, cnt >= 99});
        chk("tick_hi", 32'h1, {31'h0, cnt <= 100});
        // second reset in mid-run
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        fchk(8'h8C, 8'h22);
        rchk("filt_reg", A_FLT, 8'h02);
        give_verdict();
    end
endmodule // tb_top
